// ===== rtl/xoc_ctrl.sv
// Purpose: control of the main and low-frequency crystal oscillators
// Assumes: reference and oscillator clocks are slow against mclk_i
// Notes:   main oscillator edges are only countable below 5 MHz here
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module xoc_ctrl
	import xoc_pkg::*;
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	// system
	input  wire logic        write_protect_i,
	input  wire logic        standby_i,
	input  wire logic        ref_clk_i,
	// main oscillator
	input  wire logic        main_req_i,
	input  wire logic        main_osc_clk_i,
	output logic             main_osc_en_o,
	output logic             main_osc_ready_flag_o,
	output logic             main_auto_gain_ctrl_o,
	output logic      [2:0]  main_gain_o,
	output logic             main_crystal_mode_sel_o,
	output logic             main_out_pad_gpio_o,
	// low-frequency oscillator
	input  wire logic        lf_req_i,
	input  wire logic        lf_osc_clk_i,
	output logic             lf_osc_en_o,
	output logic             lf_ready_o,
	output logic             lf_auto_amplitude_enable_o,
	output logic             lf_low_freq_output_enable_o,
	output logic             lf_crystal_mode_sel_o
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic run_f(input logic [15:0] r, input logic stby, input logic req);
		run_f = r[ENABLE_BIT]
			& (~stby | r[STDBY_BIT])
			& (~r[REQUEST_DRIVEN_RUN_BIT] | req);
	endfunction

	function automatic logic [CNT_W-1:0] lf_ticks_f(input logic [2:0] c);
		case (c)
			3'h0: lf_ticks_f = 18'h00001;
			3'h1: lf_ticks_f = 18'h00020;
			3'h2: lf_ticks_f = 18'h00800;
			3'h3: lf_ticks_f = 18'h01000;
			3'h4: lf_ticks_f = 18'h04000;
			3'h5: lf_ticks_f = 18'h08000;
			3'h6: lf_ticks_f = 18'h10000;
			default: lf_ticks_f = 18'h20000;
		endcase
	endfunction

	// one startup sequencer step, shared by both oscillators
	function automatic xoc_osc_s step_f(input xoc_osc_s s, input logic run,
		input logic ref_tick, input logic osc_edge, input logic [CNT_W-1:0] ticks);
		xoc_osc_s n;
		n = s;
		n.en = run;
		if (!run) begin
			n.fsm = OSC_OFF;
			n.cnt = '0;
			n.sync_cnt = 2'h0;
		end else begin
			case (s.fsm)
				OSC_OFF: begin
					n.fsm = OSC_COUNT;
					n.cnt = ticks;
				end
				OSC_COUNT: begin
					if (ref_tick) begin
						if (s.cnt <= 18'h00001) begin
							n.fsm = OSC_SYNC;
							n.sync_cnt = 2'h0;
						end else begin
							n.cnt = s.cnt - 18'h00001;
						end
					end
				end
				OSC_SYNC: begin
					if (osc_edge) begin
						if (s.sync_cnt == SYNC_OSC_CYCLES - 2'h1) begin
							n.fsm = OSC_READY;
						end else begin
							n.sync_cnt = s.sync_cnt + 2'h1;
						end
					end
				end
				default: n.fsm = OSC_READY;
			endcase
		end
		return n;
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	xoc_state_s st_q;
	xoc_state_s st_d;
	logic       ref_tick;
	logic       mosc_edge;
	logic       losc_edge;
	logic       m_run;
	logic       l_run;
	logic       wr_ok;
	logic [CNT_W-1:0] main_ticks;
	logic [CNT_W-1:0] lf_ticks;

	assign ref_tick  = st_q.ref_sync[1] & ~st_q.ref_sync[2];
	assign mosc_edge = st_q.mosc_sync[1] & ~st_q.mosc_sync[2];
	assign losc_edge = st_q.losc_sync[1] & ~st_q.losc_sync[2];
	assign m_run     = run_f(st_q.main_reg, standby_i, main_req_i);
	assign l_run     = run_f(st_q.lf_reg, standby_i, lf_req_i);
	assign wr_ok     = wr_i & ~write_protect_i;
	assign main_ticks = CNT_W'(18'h00001 << st_q.main_reg[MAIN_START_LSB +: 4]);
	assign lf_ticks   = lf_ticks_f(st_q.lf_reg[LF_START_LSB +: 3]);

	always_comb begin
		st_d = st_q;
		// pins pass two flops; the third only remembers for the edge
		st_d.ref_sync  = {st_q.ref_sync[1:0], ref_clk_i};
		st_d.mosc_sync = {st_q.mosc_sync[1:0], main_osc_clk_i};
		st_d.losc_sync = {st_q.losc_sync[1:0], lf_osc_clk_i};
		if (wr_ok && addr_i == MAIN_CTRL_OFS) begin
			st_d.main_reg = wdata_i & MAIN_CTRL_MASK;
		end else if (wr_ok && addr_i == LF_CTRL_OFS && !st_q.lf_reg[LF_LOCK_BIT]) begin
			st_d.lf_reg = wdata_i & LF_CTRL_MASK;
		end
		if (rd_i && addr_i == MAIN_CTRL_OFS) begin
			st_d.rdata = st_q.main_reg;
		end else if (rd_i && addr_i == LF_CTRL_OFS) begin
			st_d.rdata = st_q.lf_reg;
		end else begin
			st_d.rdata = 16'h0000;
		end
		st_d.m = step_f(st_q.m, m_run, ref_tick, mosc_edge,
			main_ticks);
		st_d.l = step_f(st_q.l, l_run, ref_tick, losc_edge,
			lf_ticks);
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st_q          <= '0;
			st_q.main_reg <= MAIN_CTRL_RST;
			st_q.lf_reg   <= LF_CTRL_RST;
			st_q.m.fsm    <= OSC_OFF;
			st_q.l.fsm    <= OSC_OFF;
		end else begin
			st_q <= st_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// gain is forced neutral under auto gain so a stale code cannot leak
	assign rdata_o                     = st_q.rdata;
	assign main_osc_en_o               = st_q.m.en;
	assign main_osc_ready_flag_o       = st_q.m.fsm == OSC_READY;
	assign main_auto_gain_ctrl_o       = st_q.m.en & st_q.main_reg[MAIN_AGC_BIT];
	assign main_gain_o                 = st_q.main_reg[MAIN_AGC_BIT] ? GAIN_NONE
		: st_q.main_reg[MAIN_GAIN_LSB +: 3];
	assign main_crystal_mode_sel_o     = st_q.main_reg[XTAL_BIT];
	assign main_out_pad_gpio_o         = ~st_q.main_reg[XTAL_BIT];
	assign lf_osc_en_o                 = st_q.l.en;
	assign lf_ready_o                  = st_q.l.fsm == OSC_READY;
	assign lf_auto_amplitude_enable_o  = st_q.lf_reg[LF_AAMP_BIT];
	assign lf_low_freq_output_enable_o = st_q.lf_reg[LF_OUT_EN_BIT];
	assign lf_crystal_mode_sel_o       = st_q.lf_reg[XTAL_BIT];

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	chk_ready_needs_run: assert property (main_osc_ready_flag_o |-> main_osc_en_o)
		else $error("main ready without running oscillator");
	chk_off_clears_ready: assert property (!m_run |=> !main_osc_ready_flag_o && !main_osc_en_o)
		else $error("ready survived turn off");
	chk_ready_after_sync: assert property ($rose(main_osc_ready_flag_o)
		|-> $past(st_q.m.fsm) == OSC_SYNC && $past(mosc_edge))
		else $error("ready rose without sync edge");
	chk_agc_gain_quiet: assert property (st_q.main_reg[MAIN_AGC_BIT] |-> main_gain_o == GAIN_NONE)
		else $error("gain driven under auto gain");
	chk_standby_stops: assert property (standby_i && !st_q.main_reg[STDBY_BIT]
		|=> !main_osc_en_o)
		else $error("oscillator ran in standby");
	chk_request_driven_run_idle: assert property (st_q.main_reg[REQUEST_DRIVEN_RUN_BIT] && !main_req_i
		|=> !main_osc_en_o)
		else $error("on demand oscillator ran without request");
	chk_continuous_run: assert property (st_q.main_reg[ENABLE_BIT] && !st_q.main_reg[REQUEST_DRIVEN_RUN_BIT]
		&& !standby_i |=> main_osc_en_o)
		else $error("enabled oscillator not running");
	chk_lock_freezes: assert property (st_q.lf_reg[LF_LOCK_BIT] |=> $stable(st_q.lf_reg))
		else $error("locked register changed");
	chk_protect_holds: assert property (write_protect_i |=> $stable(st_q.main_reg))
		else $error("protected register changed");
	chk_count_on_ref: assert property (st_q.m.fsm == OSC_COUNT && m_run && !ref_tick
		|=> $stable(st_q.m.cnt))
		else $error("startup counter moved without reference tick");
	// the count is loaded from the field as it stood when the run began
	chk_start_load: assert property ($rose(main_osc_en_o)
		|-> st_q.m.fsm == OSC_COUNT && st_q.m.cnt == $past(main_ticks))
		else $error("main startup count loaded wrong");
	chk_count_step: assert property (st_q.m.fsm == OSC_COUNT && m_run && ref_tick
		&& st_q.m.cnt > 18'h00001 |=> st_q.m.cnt == $past(st_q.m.cnt) - 18'h00001)
		else $error("main startup count did not step on tick");
	chk_sync_hold: assert property (st_q.m.fsm == OSC_SYNC && m_run && !mosc_edge
		|=> $stable(st_q.m.sync_cnt))
		else $error("sync counter moved without oscillator edge");
	chk_enable_off_stops: assert property (!st_q.main_reg[ENABLE_BIT]
		|=> !main_osc_en_o)
		else $error("main oscillator ran while disabled");
	chk_gain_manual: assert property (!st_q.main_reg[MAIN_AGC_BIT]
		|-> main_gain_o == st_q.main_reg[MAIN_GAIN_LSB +: 3])
		else $error("manual gain not passed to pad");
	chk_pads_exclusive: assert property (main_crystal_mode_sel_o != main_out_pad_gpio_o)
		else $error("output pad both crystal and general purpose");

	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	chk_main_reserved_zero: assert property (rd_i && addr_i == MAIN_CTRL_OFS
		|=> (rdata_o & ~MAIN_CTRL_MASK) == 16'h0000)
		else $error("main reserved bits read nonzero");
	chk_lf_reserved_zero: assert property (rd_i && addr_i == LF_CTRL_OFS
		|=> (rdata_o & ~LF_CTRL_MASK) == 16'h0000)
		else $error("low frequency reserved bits read nonzero");
	chk_lf_lock_sticks: assert property (st_q.lf_reg[LF_LOCK_BIT] |=> st_q.lf_reg[LF_LOCK_BIT])
		else $error("lock bit released without reset");

	// ---------------------------------------------------------------
	// low-frequency oscillator
	// ---------------------------------------------------------------
	// same sequencer as the main one, so the checks mirror it, except the count step, sync hold and continuous run checks
	chk_lf_ready_needs_run: assert property (lf_ready_o |-> lf_osc_en_o)
		else $error("low frequency ready without running oscillator");
	chk_lf_off_clears: assert property (!l_run |=> !lf_ready_o && !lf_osc_en_o)
		else $error("low frequency ready survived turn off");
	chk_lf_ready_after_sync: assert property ($rose(lf_ready_o)
		|-> $past(st_q.l.fsm) == OSC_SYNC && $past(losc_edge))
		else $error("low frequency ready rose without sync edge");
	chk_lf_count_on_ref: assert property (st_q.l.fsm == OSC_COUNT && l_run && !ref_tick
		|=> $stable(st_q.l.cnt))
		else $error("low frequency counter moved without reference tick");
	chk_lf_start_load: assert property ($rose(lf_osc_en_o)
		|-> st_q.l.fsm == OSC_COUNT && st_q.l.cnt == $past(lf_ticks))
		else $error("low frequency startup count loaded wrong");
	chk_lf_protect_holds: assert property (write_protect_i |=> $stable(st_q.lf_reg))
		else $error("protected low frequency register changed");
	chk_lf_enable_off: assert property (!st_q.lf_reg[ENABLE_BIT]
		|=> !lf_osc_en_o)
		else $error("low frequency oscillator ran while disabled");
	chk_lf_standby_stops: assert property (standby_i && !st_q.lf_reg[STDBY_BIT]
		|=> !lf_osc_en_o)
		else $error("low frequency oscillator ran in standby");
	chk_lf_request_driven_run_idle: assert property (st_q.lf_reg[REQUEST_DRIVEN_RUN_BIT] && !lf_req_i
		|=> !lf_osc_en_o)
		else $error("low frequency oscillator ran without request");

	// main scenarios that the bench should reach
	cov_main_ready: cover property (main_osc_en_o ##1 main_osc_ready_flag_o);
	cov_lf_ready: cover property ($rose(lf_ready_o));
	cov_lock_write: cover property (st_q.lf_reg[LF_LOCK_BIT] && wr_i && addr_i == LF_CTRL_OFS);
	cov_standby_run: cover property (standby_i && main_osc_en_o);
	cov_protect_write: cover property (write_protect_i && wr_i);
endmodule

// ===== rtl/xoc_pkg.sv
// Purpose: shared constants and types for the crystal oscillator control block
// Assumes: 16-bit registers at byte offsets on a plain strobe port
// Notes:   reference and oscillator clocks arrive as pins and are sampled
package xoc_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0]  MAIN_CTRL_OFS   = 8'h10;
	localparam logic [7:0]  LF_CTRL_OFS     = 8'h14;
	localparam logic [15:0] MAIN_CTRL_RST   = 16'h0080;
	localparam logic [15:0] LF_CTRL_RST     = 16'h0080;
	localparam logic [15:0] MAIN_CTRL_MASK  = 16'hffc6;
	localparam logic [15:0] LF_CTRL_MASK    = 16'h17ee;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int MAIN_START_LSB = 12;
	localparam int MAIN_AGC_BIT   = 11;
	localparam int MAIN_GAIN_LSB  = 8;
	localparam int LF_LOCK_BIT    = 12;
	localparam int LF_START_LSB   = 8;
	localparam int REQUEST_DRIVEN_RUN_BIT   = 7;
	localparam int STDBY_BIT      = 6;
	localparam int LF_AAMP_BIT    = 5;
	localparam int LF_OUT_EN_BIT  = 3;
	localparam int XTAL_BIT       = 2;
	localparam int ENABLE_BIT     = 1;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam logic [1:0]  SYNC_OSC_CYCLES = 2'h3;
	localparam int          CNT_W           = 18;
	localparam logic [2:0]  GAIN_NONE       = 3'h0;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		OSC_OFF,
		OSC_COUNT,
		OSC_SYNC,
		OSC_READY
	} xoc_fsm_e;
	typedef struct packed {
		xoc_fsm_e         fsm;
		logic [CNT_W-1:0] cnt;
		logic [1:0]       sync_cnt;
		logic             en;
	} xoc_osc_s;
	typedef struct packed {
		logic [15:0] main_reg;
		logic [15:0] lf_reg;
		logic [15:0] rdata;
		logic [2:0]  ref_sync;
		logic [2:0]  mosc_sync;
		logic [2:0]  losc_sync;
		xoc_osc_s    m;
		xoc_osc_s    l;
	} xoc_state_s;
endpackage

// ===== tb/xoc_osc_model.sv
// Purpose: pad-side crystal sources and the always-on reference clock
// Assumes: reference at mclk/8, oscillators at mclk/10
// Notes:   a crystal stands still, low, while its enable is off
`timescale 1ns/1ps
module xoc_osc_model #(
	parameter int REF_HALF_NS  = 400,
	parameter int MAIN_HALF_NS = 500,
	parameter int LF_HALF_NS   = 500
) (
	// enables from the block
	input  wire logic main_en_i,
	input  wire logic lf_en_i,
	// clocks to the block
	output logic      ref_clk_o,
	output logic      main_clk_o,
	output logic      lf_clk_o
);
	// ---------------------------------------------------------------
	// reference never gated, crystals swing only while powered
	// ---------------------------------------------------------------
	initial begin
		ref_clk_o = 1'b0;
		forever #(REF_HALF_NS) ref_clk_o = ~ref_clk_o;
	end
	always begin
		main_clk_o = 1'b0;
		wait (main_en_i === 1'b1);
		while (main_en_i === 1'b1) #(MAIN_HALF_NS) main_clk_o = ~main_clk_o;
	end
	always begin
		lf_clk_o = 1'b0;
		wait (lf_en_i === 1'b1);
		while (lf_en_i === 1'b1) #(LF_HALF_NS) lf_clk_o = ~lf_clk_o;
	end
endmodule

// ===== tb/xoc_ctrl_test.sv
// Purpose: self-checking bench for the crystal oscillator control block
// Assumes: short startup codes keep the run brief
// Notes:   ready windows allow for synchroniser latency
`timescale 1ns/1ps
module xoc_ctrl_test;
	import xoc_pkg::*;
	logic        mclk_i, rst_n_i, wr_i, rd_i, wp, sb, mreq, lreq;
	logic [7:0]  addr_i;
	logic [15:0] wdata_i, rdata_o;
	logic        refc, mclk_x, lclk_x, men, mrdy, magc, mxtal, mgpio;
	logic        len, lrdy, laamp, lout, lxtal;
	logic [2:0]  mgain;
	logic [3:0]  codes [3] = '{4'h0, 4'h1, 4'h5};
	int          fail_count, num_checks, n;
	// ---------------------------------------------------------------
	// design and pad-side partner
	// ---------------------------------------------------------------
	xoc_ctrl dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .write_protect_i(wp), .standby_i(sb),
		.ref_clk_i(refc), .main_req_i(mreq), .main_osc_clk_i(mclk_x), .main_osc_en_o(men),
		.main_osc_ready_flag_o(mrdy), .main_auto_gain_ctrl_o(magc), .main_gain_o(mgain),
		.main_crystal_mode_sel_o(mxtal), .main_out_pad_gpio_o(mgpio), .lf_req_i(lreq),
		.lf_osc_clk_i(lclk_x), .lf_osc_en_o(len), .lf_ready_o(lrdy),
		.lf_auto_amplitude_enable_o(laamp), .lf_low_freq_output_enable_o(lout),
		.lf_crystal_mode_sel_o(lxtal));
	xoc_osc_model osc_u (.main_en_i(men), .lf_en_i(len), .ref_clk_o(refc),
		.main_clk_o(mclk_x), .lf_clk_o(lclk_x));
	// ---------------------------------------------------------------
	// access and check tasks
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk(what, rdata_o, exp);
	endtask
	task automatic settle;
		repeat (3) @(posedge mclk_i);
		#1;
	endtask
	// bounded wait, so a stuck flag cannot hang the run
	task automatic wait_rdy(input bit lf, output int c);
		c = 0;
		while ((lf ? lrdy : mrdy) !== 1'b1 && c < 2000) begin
			@(posedge mclk_i);
			c++;
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// clock, watchdog and tests
	// ---------------------------------------------------------------
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		#3_000_000;
		fail_count++;
		tally_and_finish;
	end
	initial begin
		{rst_n_i, wr_i, rd_i, wp, sb, lreq, addr_i, wdata_i} = '0;
		mreq = 1'b1;
		repeat (5) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		rd(MAIN_CTRL_OFS, MAIN_CTRL_RST, "main rst");
		rd(LF_CTRL_OFS, LF_CTRL_RST, "lf rst");
		rd(8'h18, 16'h0000, "unmapped");
		wr(MAIN_CTRL_OFS, 16'hffff);
		rd(MAIN_CTRL_OFS, 16'hffc6, "main mask");
		settle;
		chk("agc gain", 16'({magc, mgain}), 16'h8);
		chk("crystal pads", 16'({mxtal, mgpio}), 16'h2);
		wr(MAIN_CTRL_OFS, 16'h0400);
		settle;
		chk("manual gain", 16'({magc, mgain}), 16'h4);
		chk("ext clk pads", 16'({mxtal, mgpio, men}), 16'h2);
		$display("test registers done");
		// ready never early, never late, cleared on stop
		foreach (codes[i]) begin
			wr(MAIN_CTRL_OFS, {codes[i], 12'h002});
			wait_rdy(1'b0, n);
			chk("rdy early", 16'(n >= 8 * ((1 << codes[i]) - 1) + 20), 16'h1);
			chk("rdy late", 16'(n <= 8 * (1 << codes[i]) + 60), 16'h1);
			wr(MAIN_CTRL_OFS, 16'h0000);
			settle;
			chk("rdy off", 16'({men, mrdy}), 16'h0);
		end
		$display("test startup done");
		@(posedge mclk_i) mreq <= 1'b0;
		wr(MAIN_CTRL_OFS, 16'h0082);
		settle;
		chk("od idle", 16'(men), 16'h0);
		@(posedge mclk_i) mreq <= 1'b1;
		settle;
		chk("od req", 16'(men), 16'h1);
		@(posedge mclk_i) sb <= 1'b1;
		settle;
		chk("sb stop", 16'({men, mrdy}), 16'h0);
		wr(MAIN_CTRL_OFS, 16'h00c2);
		settle;
		chk("sb od", 16'(men), 16'h1);
		wr(MAIN_CTRL_OFS, 16'h0042);
		@(posedge mclk_i) mreq <= 1'b0;
		settle;
		chk("sb cont", 16'(men), 16'h1);
		@(posedge mclk_i) sb <= 1'b0;
		@(posedge mclk_i) wp <= 1'b1;
		wr(MAIN_CTRL_OFS, 16'h0000);
		rd(MAIN_CTRL_OFS, 16'h0042, "wprot");
		@(posedge mclk_i) wp <= 1'b0;
		$display("test modes done");
		wr(LF_CTRL_OFS, 16'hf8ae);
		rd(LF_CTRL_OFS, 16'h10ae, "lf mask");
		settle;
		chk("lf outs", 16'({laamp, lout, lxtal, len}), 16'he);
		@(posedge mclk_i) lreq <= 1'b1;
		wait_rdy(1'b1, n);
		chk("lf rdy", 16'(n >= 20 && n <= 68), 16'h1);
		wr(LF_CTRL_OFS, 16'h0000);
		rd(LF_CTRL_OFS, 16'h10ae, "lf lock");
		$display("test low freq done");
		tally_and_finish;
	end
endmodule
